// File: logic/gcf_force_bits.sv
`timescale 1ns/1ps
module gcf_force_bits #(
  parameter logic [gcf_pkg::FORCE_W-1:0] PRESENT = 3'h7
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [gcf_pkg::FORCE_W-1:0] set_req,
  input wire logic [gcf_pkg::FORCE_W-1:0] clr_req,
  output logic [gcf_pkg::FORCE_W-1:0] force_q
);
  // absent fields never leave zero; set wins over clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      force_q <= gcf_pkg::FORCE_RESET;
    end else begin
      force_q <= ((force_q & ~clr_req) | set_req) & PRESENT; // R1 R2 R4 R5 R7
    end
  end
endmodule

// File: logic/gcf_pkg.sv
// Functional notes
// (R1) writing one to set bits 3, 2, 1 forces trace, bus, core clocks
// (R2) writing one to the same clear bits drops the force; zero ignored
// (R3) set and clear registers are write-only pulse modifiers, nothing stored
// (R4) bit 3 of set and clear exists only when capability bit 1 is one
// (R5) bit 1 of set and clear exists only when capability bit 0 is one
// (R6) capability bit 1 reads one when trace analyzer support is built
// (R7) without trace analyzer support its fields read zero and ignore writes
// (R8) capability bit 0 reads one when core clock gating is supported
// (R9) capability register is read-only, build fixed, bits 31 to 2 zero
// (R10) configuration bits 31 to 16 give a fixed unit identity
// (R11) configuration bits 3 to 0 give policy unit count, one; 15 to 4 zero
// (R12) ident 4 bits 7 to 4 give log2 of 4KB blocks, 64KB footprint
// (R13) ident 4 bits 3 to 0 give fixed maker continuation count
// (R14) ident 0 bits 7 to 0 give part number low byte, rest zero
// (R15) force state register mirrors force bits; one means gating disabled
// (R16) set and clear read as zero; same-bit set and clear not expected
package gcf_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int FORCE_W = 3;
  localparam logic [ADDR_W-1:0] OFS_FORCE_SET = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_FORCE_CLEAR = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_FORCE_STATE = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CAPABILITY = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_UNIT_CONFIG = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_IDENT_4 = 12'hfd0;
  localparam logic [ADDR_W-1:0] OFS_IDENT_0 = 12'hfe0;
  // force fields occupy bits 3:1; index 0 of the force vector is bit 1
  localparam int FORCE_LSB = 1;
  localparam int IDX_CORE = 0;
  localparam int IDX_BUS = 1;
  localparam int IDX_TRACE = 2;
  localparam int CAP_CORE_BIT = 0;
  localparam int CAP_TRACE_BIT = 1;
  localparam int CFG_ID_LSB = 16;
  localparam int CFG_ID_W = 16;
  localparam int CFG_COUNT_W = 4;
  localparam int PERIPHERAL_IDENT_4_FOOT_LSB = 4;
  localparam logic [3:0] FOOTPRINT_LOG2 = 4'h4;
  localparam logic [3:0] POLICY_UNIT_COUNT = 4'h1;
  localparam logic [FORCE_W-1:0] FORCE_RESET = 3'h0;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
endpackage

// File: logic/gcf_regs.sv
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module gcf_regs #(
  parameter bit TRACE_SUPPORT = 1'b1,
  parameter bit CORE_GATING = 1'b1,
  // identity values below are arbitrary
  parameter logic [15:0] UNIT_ID = 16'h5a3c,
  parameter logic [3:0] MAKER_CONT = 4'h3,
  parameter logic [7:0] PART_LOW = 8'h5c
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gcf_pkg::ADDR_W-1:0] paddr,
  input wire logic [gcf_pkg::DATA_W-1:0] pwdata,
  output logic [gcf_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic trace_analyzer_force,
  output logic bus_clock_force,
  output logic core_clock_force
);
  localparam logic [gcf_pkg::FORCE_W-1:0] PRESENT = {TRACE_SUPPORT, 1'b1, CORE_GATING};

  logic [gcf_pkg::FORCE_W-1:0] force_vec;
  logic [gcf_pkg::FORCE_W-1:0] set_req;
  logic [gcf_pkg::FORCE_W-1:0] clr_req;
  logic setup;
  logic wr_en;
  logic rd_hit;
  logic [gcf_pkg::DATA_W-1:0] rd_word;
  logic wr_set;
  logic wr_clr;
  logic rd_setup;

  // read value and hit flag for an address
  function automatic logic [gcf_pkg::DATA_W:0] decode(
    input logic [gcf_pkg::ADDR_W-1:0] addr,
    input logic [gcf_pkg::FORCE_W-1:0] fv
  );
    logic [gcf_pkg::DATA_W-1:0] w;
    logic hit;
    w = gcf_pkg::ZERO_WORD;
    hit = 1'b1;
    unique case (addr)
      gcf_pkg::OFS_FORCE_SET: w = gcf_pkg::ZERO_WORD; // R3 R16
      gcf_pkg::OFS_FORCE_CLEAR: w = gcf_pkg::ZERO_WORD; // R3 R16
      gcf_pkg::OFS_FORCE_STATE: w[gcf_pkg::FORCE_LSB +: gcf_pkg::FORCE_W] = fv; // R15
      gcf_pkg::OFS_CAPABILITY: begin
        w[gcf_pkg::CAP_TRACE_BIT] = TRACE_SUPPORT; // R6 R9
        w[gcf_pkg::CAP_CORE_BIT] = CORE_GATING; // R8
      end
      gcf_pkg::OFS_UNIT_CONFIG: begin
        w[gcf_pkg::CFG_ID_LSB +: gcf_pkg::CFG_ID_W] = UNIT_ID; // R10
        w[gcf_pkg::CFG_COUNT_W-1:0] = gcf_pkg::POLICY_UNIT_COUNT; // R11
      end
      gcf_pkg::OFS_IDENT_4: begin
        w[gcf_pkg::PERIPHERAL_IDENT_4_FOOT_LSB +: 4] = gcf_pkg::FOOTPRINT_LOG2; // R12
        w[3:0] = MAKER_CONT; // R13
      end
      gcf_pkg::OFS_IDENT_0: w[7:0] = PART_LOW; // R14
      default: hit = 1'b0;
    endcase
    return {hit, w};
  endfunction

  assign setup = psel && !penable && !pready;
  assign {rd_hit, rd_word} = decode(paddr, force_vec);
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign wr_set = wr_en && paddr == gcf_pkg::OFS_FORCE_SET;
  assign wr_clr = wr_en && paddr == gcf_pkg::OFS_FORCE_CLEAR;
  assign rd_setup = setup && !pwrite;

  // set and clear are pulses, nothing is stored for them
  always_comb begin
    set_req = '0;
    clr_req = '0;
    if (wr_en && paddr == gcf_pkg::OFS_FORCE_SET) begin
      set_req = pwdata[gcf_pkg::FORCE_LSB +: gcf_pkg::FORCE_W]; // R1 R3
    end
    if (wr_en && paddr == gcf_pkg::OFS_FORCE_CLEAR) begin
      clr_req = pwdata[gcf_pkg::FORCE_LSB +: gcf_pkg::FORCE_W]; // R2 R3
    end
  end

  gcf_force_bits #(
    .PRESENT(PRESENT)
  ) u_force (
    .mclk(mclk),
    .rst_n(rst_n),
    .set_req(set_req),
    .clr_req(clr_req),
    .force_q(force_vec)
  );

  assign trace_analyzer_force = force_vec[gcf_pkg::IDX_TRACE];
  assign bus_clock_force = force_vec[gcf_pkg::IDX_BUS];
  assign core_clock_force = force_vec[gcf_pkg::IDX_CORE];

  // one wait-free access phase after each setup
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // read data and error captured at setup, cleared after access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= gcf_pkg::ZERO_WORD;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? gcf_pkg::ZERO_WORD : rd_word;
      pslverr <= !rd_hit;
    end else begin
      prdata <= gcf_pkg::ZERO_WORD;
      pslverr <= 1'b0;
    end
  end

  a_set_bus: assert property (@(posedge mclk) disable iff (!rst_n) // R1
    wr_en && paddr == gcf_pkg::OFS_FORCE_SET && pwdata[2] |=> bus_clock_force)
    else $error("bus clock force not set");

  a_set_core: assert property (@(posedge mclk) disable iff (!rst_n) // R1
    wr_en && paddr == gcf_pkg::OFS_FORCE_SET && pwdata[1] |=> core_clock_force == CORE_GATING)
    else $error("core clock force wrong after set");

  a_clear_bus: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    wr_en && paddr == gcf_pkg::OFS_FORCE_CLEAR && pwdata[2] |=> !bus_clock_force)
    else $error("bus clock force not cleared");

  a_zero_ignored: assert property (@(posedge mclk) disable iff (!rst_n) // R1
    wr_en && paddr == gcf_pkg::OFS_FORCE_SET && !pwdata[3] |=> $stable(trace_analyzer_force))
    else $error("zero write changed trace force");

  a_trace_absent: assert property (@(posedge mclk) disable iff (!rst_n) // R4
    !TRACE_SUPPORT |-> !trace_analyzer_force)
    else $error("absent trace force bit moved");

  a_core_absent: assert property (@(posedge mclk) disable iff (!rst_n) // R5
    !CORE_GATING |-> !core_clock_force)
    else $error("absent core force bit moved");

  a_wo_read_zero: assert property (@(posedge mclk) disable iff (!rst_n) // R16
    setup && !pwrite && (paddr == gcf_pkg::OFS_FORCE_SET || paddr == gcf_pkg::OFS_FORCE_CLEAR)
    |=> pready && prdata == gcf_pkg::ZERO_WORD && !pslverr)
    else $error("write-only register read not zero");

  a_cap_read: assert property (@(posedge mclk) disable iff (!rst_n) // R9
    setup && !pwrite && paddr == gcf_pkg::OFS_CAPABILITY
    |=> prdata == {30'h0, TRACE_SUPPORT, CORE_GATING})
    else $error("capability read wrong");

  a_config_read: assert property (@(posedge mclk) disable iff (!rst_n) // R11
    setup && !pwrite && paddr == gcf_pkg::OFS_UNIT_CONFIG
    |=> prdata == {UNIT_ID, 12'h000, gcf_pkg::POLICY_UNIT_COUNT})
    else $error("configuration read wrong");

  a_state_mirror: assert property (@(posedge mclk) disable iff (!rst_n) // R15
    setup && !pwrite && paddr == gcf_pkg::OFS_FORCE_STATE
    |=> prdata == {28'h0, $past(force_vec), 1'b0})
    else $error("force state read wrong");

  a_ident_reads: assert property (@(posedge mclk) disable iff (!rst_n) // R12
    setup && !pwrite && paddr == gcf_pkg::OFS_IDENT_4
    |=> prdata == {24'h0, gcf_pkg::FOOTPRINT_LOG2, MAKER_CONT})
    else $error("ident 4 read wrong");

  a_ident0_read: assert property (@(posedge mclk) disable iff (!rst_n) // R14
    setup && !pwrite && paddr == gcf_pkg::OFS_IDENT_0 |=> prdata == {24'h0, PART_LOW})
    else $error("ident 0 read wrong");

  a_ready_once: assert property (@(posedge mclk) disable iff (!rst_n)
    pready |=> !pready ##1 1'b1)
    else $error("ready held too long");

  a_set_trace: assert property (@(posedge mclk) disable iff (!rst_n) // R1
    wr_set && pwdata[3]
    |=> trace_analyzer_force == TRACE_SUPPORT)
    else $error("trace clock force wrong after set");

  a_clear_trace: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    wr_clr && pwdata[3]
    |=> !trace_analyzer_force)
    else $error("trace clock force not cleared");

  a_clear_core: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    wr_clr && pwdata[1]
    |=> !core_clock_force)
    else $error("core clock force not cleared");

  a_zero_bus: assert property (@(posedge mclk) disable iff (!rst_n) // R1
    wr_set && !pwdata[2]
    |=> $stable(bus_clock_force))
    else $error("zero write changed bus force");

  a_zero_core: assert property (@(posedge mclk) disable iff (!rst_n) // R1
    wr_set && !pwdata[1]
    |=> $stable(core_clock_force))
    else $error("zero write changed core force");

  a_clr_zero_trace: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    wr_clr && !pwdata[3]
    |=> $stable(trace_analyzer_force))
    else $error("zero clear changed trace force");

  a_clr_zero_bus: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    wr_clr && !pwdata[2]
    |=> $stable(bus_clock_force))
    else $error("zero clear changed bus force");

  a_clr_zero_core: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    wr_clr && !pwdata[1]
    |=> $stable(core_clock_force))
    else $error("zero clear changed core force");

  a_idle_hold: assert property (@(posedge mclk) disable iff (!rst_n) // R3
    !wr_set && !wr_clr
    |=> $stable({trace_analyzer_force, bus_clock_force, core_clock_force}))
    else $error("force changed without set or clear");

  a_err_unmapped: assert property (@(posedge mclk) disable iff (!rst_n)
    setup && !rd_hit
    |=> pready && pslverr)
    else $error("unmapped access not refused");

  a_err_mapped: assert property (@(posedge mclk) disable iff (!rst_n)
    setup && rd_hit
    |=> !pslverr)
    else $error("mapped access refused");

  a_ready_follows: assert property (@(posedge mclk) disable iff (!rst_n)
    setup
    |=> pready)
    else $error("ready missing after setup");

  a_ready_needs_setup: assert property (@(posedge mclk) disable iff (!rst_n)
    !setup
    |=> !pready)
    else $error("ready without setup");

  a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    !pready
    |-> prdata == gcf_pkg::ZERO_WORD)
    else $error("read data outside access");

  a_err_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    !pready
    |-> !pslverr)
    else $error("error outside access");

  a_write_rdata_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    setup && pwrite
    |=> prdata == gcf_pkg::ZERO_WORD)
    else $error("read data during write");

  a_cap_reserved: assert property (@(posedge mclk) disable iff (!rst_n) // R9
    rd_setup && paddr == gcf_pkg::OFS_CAPABILITY
    |=> prdata[31:2] == 30'h0)
    else $error("capability reserved bits set");

  a_cap_trace: assert property (@(posedge mclk) disable iff (!rst_n) // R6
    rd_setup && paddr == gcf_pkg::OFS_CAPABILITY
    |=> prdata[gcf_pkg::CAP_TRACE_BIT] == TRACE_SUPPORT)
    else $error("capability trace bit wrong");

  a_cap_core: assert property (@(posedge mclk) disable iff (!rst_n) // R8
    rd_setup && paddr == gcf_pkg::OFS_CAPABILITY
    |=> prdata[gcf_pkg::CAP_CORE_BIT] == CORE_GATING)
    else $error("capability core bit wrong");

  a_config_id: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    rd_setup && paddr == gcf_pkg::OFS_UNIT_CONFIG
    |=> prdata[31:16] == UNIT_ID)
    else $error("unit identity wrong");

  a_config_reserved: assert property (@(posedge mclk) disable iff (!rst_n) // R11
    rd_setup && paddr == gcf_pkg::OFS_UNIT_CONFIG
    |=> prdata[15:4] == 12'h000)
    else $error("configuration reserved bits set");

  a_ident4_foot: assert property (@(posedge mclk) disable iff (!rst_n) // R12
    rd_setup && paddr == gcf_pkg::OFS_IDENT_4
    |=> prdata[7:4] == gcf_pkg::FOOTPRINT_LOG2)
    else $error("footprint field wrong");

  a_ident4_maker: assert property (@(posedge mclk) disable iff (!rst_n) // R13
    rd_setup && paddr == gcf_pkg::OFS_IDENT_4
    |=> prdata[3:0] == MAKER_CONT)
    else $error("continuation count wrong");

  a_ident0_reserved: assert property (@(posedge mclk) disable iff (!rst_n) // R14
    rd_setup && paddr == gcf_pkg::OFS_IDENT_0
    |=> prdata[31:8] == 24'h0)
    else $error("ident 0 reserved bits set");

  a_state_reserved: assert property (@(posedge mclk) disable iff (!rst_n) // R15
    rd_setup && paddr == gcf_pkg::OFS_FORCE_STATE
    |=> prdata[31:4] == 28'h0 && !prdata[0])
    else $error("force state reserved bits set");

  a_state_trace_absent: assert property (@(posedge mclk) disable iff (!rst_n) // R7
    rd_setup && paddr == gcf_pkg::OFS_FORCE_STATE && !TRACE_SUPPORT
    |=> !prdata[3])
    else $error("absent trace state not zero");

  a_state_core_absent: assert property (@(posedge mclk) disable iff (!rst_n) // R5
    rd_setup && paddr == gcf_pkg::OFS_FORCE_STATE && !CORE_GATING
    |=> !prdata[1])
    else $error("absent core state not zero");

  a_trace_rise_cause: assert property (@(posedge mclk) disable iff (!rst_n) // R1
    $rose(trace_analyzer_force)
    |-> $past(set_req[gcf_pkg::IDX_TRACE]))
    else $error("trace force rose without set");

  a_trace_fall_cause: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    $fell(trace_analyzer_force)
    |-> $past(clr_req[gcf_pkg::IDX_TRACE]))
    else $error("trace force fell without clear");

  a_bus_rise_cause: assert property (@(posedge mclk) disable iff (!rst_n) // R1
    $rose(bus_clock_force)
    |-> $past(set_req[gcf_pkg::IDX_BUS]))
    else $error("bus force rose without set");

  a_bus_fall_cause: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    $fell(bus_clock_force)
    |-> $past(clr_req[gcf_pkg::IDX_BUS]))
    else $error("bus force fell without clear");

  a_core_rise_cause: assert property (@(posedge mclk) disable iff (!rst_n) // R1
    $rose(core_clock_force)
    |-> $past(set_req[gcf_pkg::IDX_CORE]))
    else $error("core force rose without set");

  a_core_fall_cause: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    $fell(core_clock_force)
    |-> $past(clr_req[gcf_pkg::IDX_CORE]))
    else $error("core force fell without clear");

  a_err_with_ready: assert property (@(posedge mclk) disable iff (!rst_n)
    pslverr
    |-> pready)
    else $error("error without ready");

  a_cap_write_quiet: assert property (@(posedge mclk) disable iff (!rst_n) // R9
    wr_en && paddr == gcf_pkg::OFS_CAPABILITY
    |=> $stable({trace_analyzer_force, bus_clock_force, core_clock_force}))
    else $error("capability write changed force");
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic trace_analyzer_force, bus_clock_force, core_clock_force;
  logic lite_trace, lite_bus, lite_core;
  logic [32:0] exp_q[$];
  logic [2:0] frc;
  int n_mismatch, n_compared, seed;
  gcf_regs dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trace_analyzer_force(trace_analyzer_force), .bus_clock_force(bus_clock_force),
    .core_clock_force(core_clock_force));
  gcf_regs #(.TRACE_SUPPORT(1'b0), .CORE_GATING(1'b0)) dut_lite_u (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .trace_analyzer_force(lite_trace), .bus_clock_force(lite_bus), .core_clock_force(lite_core));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_force(input logic [2:0] got, input logic [2:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t force got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one apb transfer, entered just after a rising edge; expected {pslverr, prdata} queued
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] exp);
    int n;
    n = 0;
    exp_q.push_back(exp);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(negedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] exp);
    apb(1'b0, a, 32'h0, exp);
  endtask
  // force write, then outputs and state register against the model
  task automatic wf(input logic clr, input logic [31:0] wd);
    apb(1'b1, clr ? gcf_pkg::OFS_FORCE_CLEAR : gcf_pkg::OFS_FORCE_SET, wd, 33'h0);
    frc = clr ? (frc & ~wd[3:1]) : (frc | wd[3:1]);
    @(negedge mclk);
    cmp_force({trace_analyzer_force, bus_clock_force, core_clock_force}, frc);
    cmp_force({lite_trace, lite_bus, lite_core}, {1'b0, frc[1], 1'b0});
    @(posedge mclk);
    rd(gcf_pkg::OFS_FORCE_STATE, {29'h0, frc, 1'b0});
  endtask
  // monitor: each completed access is checked against the oldest note
  always @(negedge mclk) begin
    if (psel && penable && pready) begin
      if (exp_q.size() == 0) cmp({pslverr, prdata}, 33'h1_ffff_ffff);
      else cmp({pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    #500000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    seed = 32'hd043;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    frc = 3'h0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(gcf_pkg::OFS_CAPABILITY, 33'h3);
    rd(gcf_pkg::OFS_UNIT_CONFIG, {1'b0, 16'h5a3c, 12'h0, 4'h1});
    rd(gcf_pkg::OFS_IDENT_4, {25'h0, 4'h4, 4'h3});
    rd(gcf_pkg::OFS_IDENT_0, 33'h5c);
    rd(12'h014, 33'h1_0000_0000);
    apb(1'b1, gcf_pkg::OFS_CAPABILITY, 32'hffff_ffff, 33'h0);
    rd(gcf_pkg::OFS_CAPABILITY, 33'h3);
    apb(1'b1, gcf_pkg::OFS_UNIT_CONFIG, 32'hffff_ffff, 33'h0);
    rd(gcf_pkg::OFS_UNIT_CONFIG, {1'b0, 16'h5a3c, 12'h0, 4'h1});
    for (int i = 0; i < 3; i++) begin
      wf(1'b0, 32'h2 << i);
      wf(1'b0, 32'h0);
      wf(1'b1, 32'h0);
      rd(gcf_pkg::OFS_FORCE_SET, 33'h0);
      rd(gcf_pkg::OFS_FORCE_CLEAR, 33'h0);
      wf(1'b1, 32'h2 << i);
    end
    wf(1'b0, 32'hffff_ffff);
    apb(1'b1, 12'h014, 32'h0000_000e, 33'h1_0000_0000);
    wf(1'b1, 32'h0000_0008);
    repeat (24) begin
      d = $random(seed);
      wf(d[31], d);
    end
    wf(1'b0, 32'h0000_000e);
    rst_n <= 1'b0;
    @(posedge mclk);
    frc = 3'h0;
    cmp_force({trace_analyzer_force, bus_clock_force, core_clock_force}, 3'h0);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(gcf_pkg::OFS_FORCE_STATE, 33'h0);
    report_and_stop;
  end
endmodule
